//--- bench/mrlat_checker_assertions.sv
// Checker for the mode register outputs and latency lookups.
// Assumes it is bound to mrlat_mode_reg and sees its ports only.
module mrlat_checker (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Command and selects
  input wire [2:0] cmd_in,
  input wire set_point_operate_select,
  input wire data_bus_inversion,
  input wire write_latency_set_select,
  input wire [2:0] clock_band,
  // Observed outputs
  input wire [1:0] burst_length_mode,
  input wire [1:0] wr_preamble_cycles,
  input wire [5:0] write_recovery_cycles,
  input wire [1:0] read_postamble_half,
  input wire [5:0] read_latency,
  input wire [5:0] write_latency,
  input wire rd_precharge_start,
  input wire mrr_strobe,
  input wire [7:0] mrr_data
);
  `include "mrlat_tables.svh"
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // No register write and a steady operate select for a while
  sequence quiet_s;
    (cmd_in != 3'h3 && $stable(set_point_operate_select)) [*8];
  endsequence
  // Previous cycle was out of reset, so lookups have settled
  sequence settled_s;
    !$past(sys_rst);
  endsequence
  chk_reset_fields: assert property (
    disable iff (1'b0) sys_rst |=> write_recovery_cycles == 6'h06 && burst_length_mode == 2'h0)
    else $error("fields not at reset value");
  chk_quiet_hold: assert property (
    quiet_s |-> $stable(burst_length_mode) && $stable(write_recovery_cycles))
    else $error("field changed without register write");
  chk_preamble_const: assert property (
    wr_preamble_cycles == 2'h2) else $error("write preamble not two cycles");
  chk_nwr_legal: assert property (
    write_recovery_cycles inside {6'h06, 6'h0a, 6'h10, 6'h14, 6'h18, 6'h1e, 6'h22, 6'h28})
    else $error("write recovery off table");
  chk_mrr_undef: assert property (
    mrr_strobe |-> mrr_data == 8'h00 ##1 !mrr_strobe) else $error("register read answer wrong");
  chk_rd_pulse_once: assert property (
    $rose(rd_precharge_start) |=> !rd_precharge_start [*8]) else $error("read precharge pulse long");
  chk_read_latency: assert property (
    settled_s |-> read_latency == ($past(data_bus_inversion) ? mrlat_rld[$past(clock_band)]
    : mrlat_rln[$past(clock_band)])) else $error("read latency wrong");
  chk_write_latency: assert property (
    settled_s |-> write_latency == ($past(write_latency_set_select) ?
    mrlat_wlb[$past(clock_band)] : mrlat_wla[$past(clock_band)]))
    else $error("write latency wrong");
endmodule // mrlat_checker

bind mrlat_mode_reg mrlat_checker u_mrlat_checker (.*);

//--- bench/mrlat_ctrl_model.sv
// Controller model: link clock and mode register, read and write commands.
// Assumes the bench raises run only after reset is released.
module mrlat_ctrl_model (
  // Control from the bench
  input wire run,
  // Link pins
  output logic ck_in,
  output logic [2:0] cmd_in,
  output logic [5:0] mr_addr_in,
  output logic [7:0] op_in,
  output logic burst_otf_in,
  output logic auto_precharge_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle pins at start
  initial begin
    {ck_in, cmd_in, burst_otf_in, auto_precharge_in, mr_addr_in, op_in} = '0;
  end
  // Clock stays low until run, then 320 ns period
  always begin
    #160;
    ck_in = run ? ~ck_in : 1'b0;
  end
  // Pins set half a period before ck rise, held half after, then scrambled
  task automatic send(input logic [2:0] c, input logic [5:0] a, input logic [7:0] op,
                      input logic otf, input logic ap);
    @(negedge ck_in);
    {cmd_in, mr_addr_in, op_in, burst_otf_in, auto_precharge_in} = {c, a, op, otf, ap};
    @(negedge ck_in);
    {cmd_in, mr_addr_in, op_in, burst_otf_in, auto_precharge_in} = {3'h0, ~a, ~op, ~otf, ~ap};
  endtask
endmodule // mrlat_ctrl_model

//--- bench/mrlat_mode_reg_tb_top.sv
// Testbench: fields, set points, lookups and precharge timing.
// Assumes the design, checker and controller model are compiled before it.
module mrlat_mode_reg_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `include "mrlat_defines.vh"
  `include "mrlat_tables.svh"
  logic ref_clk = 1'b0, sys_rst = 1'b1, run = 1'b0;
  logic set_point_write_select = 1'b0, set_point_operate_select = 1'b0;
  logic data_bus_inversion = 1'b0, write_latency_set_select = 1'b0;
  logic [2:0] clock_band = 3'h0;
  wire ck_in, burst_otf_in, auto_precharge_in;
  wire [2:0] cmd_in;
  wire [5:0] mr_addr_in;
  wire [7:0] op_in;
  logic [1:0] burst_length_mode, wr_preamble_cycles, read_postamble_half;
  logic wr_preamble_valid, read_preamble_toggle, burst_is_32, wr_precharge_start;
  logic rd_precharge_start, mrr_strobe, mrw_reserved;
  logic [5:0] write_recovery_cycles, read_latency, write_latency, read_to_precharge_cycles;
  logic [7:0] mrr_data;
  int fail_count = 0, checked = 0, ck_rises = 0, cycles = 0;
  mrlat_mode_reg u_mrlat_mode_reg (.*);
  mrlat_ctrl_model u_mrlat_ctrl_model (.*);
  // Clock, link edge count and hang limit
  always #20 ref_clk = ~ref_clk;
  always @(posedge ck_in) ck_rises++;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_num(input int got, input int exp);
    cmp_val(got[7:0], exp[7:0]);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic mrw(input logic [7:0] op, input logic [5:0] a);
    u_mrlat_ctrl_model.send(`MRLAT_CMD_MRW, a, op, 1'b0, 1'b0);
    tick(8);
  endtask
  // Sends a command and returns link rises from its rise to the chosen pulse
  task automatic cmd_pulse(input logic [2:0] c, input logic [7:0] op, input logic otf,
                           input logic ap, input int which, output int d);
    int s, n;
    logic [3:0] p;
    n = 0;
    p = 4'h0;
    fork
      begin
        u_mrlat_ctrl_model.send(c, `MRLAT_MR_ADDR, op, otf, ap);
        s = ck_rises;
      end
      while (p[which] !== 1'b1 && n < 500) begin
        tick(1);
        p = {mrw_reserved, rd_precharge_start, wr_precharge_start, mrr_strobe};
        n++;
      end
    join
    d = ck_rises - s;
    cmp_num(n < 500, 1);
    tick(8);
  endtask
  // Main sequence
  initial begin
    int k, d;
    logic [1:0] bmode;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_val(read_postamble_half, 8'h01);
    sys_rst = 1'b0;
    run = 1'b1;
    tick(4);
    $display("test reset done");
    for (k = 0; k < 32; k++) begin
      {write_latency_set_select, data_bus_inversion, clock_band} = k[4:0];
      tick(2);
      cmp_val(read_latency, k[3] ? mrlat_rld[k[2:0]] : mrlat_rln[k[2:0]]);
      cmp_val(write_latency, k[4] ? mrlat_wlb[k[2:0]] : mrlat_wla[k[2:0]]);
      cmp_val(read_to_precharge_cycles, mrlat_rtp[k[2:0]]);
    end
    $display("test latency done");
    for (k = 0; k < 8; k++) begin
      bmode = 2'(k % 3);
      mrw({k[0], k[2:0], k[1], 1'b1, bmode}, `MRLAT_MR_ADDR);
      cmp_val(write_recovery_cycles, mrlat_wrec[k]);
      cmp_val(burst_length_mode, bmode);
      cmp_val(wr_preamble_valid, 8'h01);
      cmp_val(read_preamble_toggle, k[1]);
      cmp_val(read_postamble_half, k[0] ? 8'h03 : 8'h01);
    end
    $display("test fields done");
    mrw(8'h04, `MRLAT_MR_ADDR);
    set_point_write_select = 1'b1;
    mrw(8'h7c, `MRLAT_MR_ADDR);
    cmp_val(write_recovery_cycles, 8'h06);
    set_point_operate_select = 1'b1;
    tick(3);
    cmp_val(write_recovery_cycles, 8'h28);
    cmp_val(read_preamble_toggle, 1'b1);
    set_point_operate_select = 1'b0;
    set_point_write_select = 1'b0;
    tick(3);
    cmp_val(write_recovery_cycles, 8'h06);
    mrw(8'h70, 6'h02);
    cmp_val(write_recovery_cycles, 8'h06);
    $display("test set points done");
    cmd_pulse(`MRLAT_CMD_MRW, 8'h07, 1'b0, 1'b0, 3, d);
    cmd_pulse(`MRLAT_CMD_MRW, 8'h00, 1'b0, 1'b0, 3, d);
    cmp_val(wr_preamble_valid, 8'h00);
    mrw(8'h04, `MRLAT_MR_ADDR);
    cmd_pulse(`MRLAT_CMD_MRR, 8'h00, 1'b0, 1'b0, 0, d);
    cmd_pulse(`MRLAT_CMD_WRITE, 8'h00, 1'b0, 1'b1, 1, d);
    cmp_num(d, 6);
    $display("test write precharge done");
    clock_band = 3'h4;
    for (k = 0; k < 3; k++) begin
      mrw(k == 0 ? 8'h05 : 8'h06, `MRLAT_MR_ADDR);
      cmd_pulse(`MRLAT_CMD_READ, 8'h00, k == 2, 1'b1, 2, d);
      cmp_num(d, k == 1 ? 10 : 18);
      cmp_val(burst_is_32, k != 1);
    end
    $display("test read precharge done");
    print_verdict();
  end
endmodule // mrlat_mode_reg_tb_top

//--- bench/mrlat_tables.svh
// Latency, write-recovery and read-to-precharge tables indexed by band or code.
// Assumes inclusion inside a module body.
localparam logic [5:0] mrlat_rln [8] = '{6'h06, 6'h0a, 6'h0e, 6'h14, 6'h18, 6'h1c, 6'h20, 6'h24};
localparam logic [5:0] mrlat_rld [8] = '{6'h06, 6'h0c, 6'h10, 6'h16, 6'h1c, 6'h20, 6'h24, 6'h28};
localparam logic [5:0] mrlat_wla [8] = '{6'h04, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h10, 6'h12};
localparam logic [5:0] mrlat_wlb [8] = '{6'h04, 6'h08, 6'h0c, 6'h12, 6'h16, 6'h1a, 6'h1e, 6'h22};
localparam logic [5:0] mrlat_wrec [8] = '{6'h06, 6'h0a, 6'h10, 6'h14, 6'h18, 6'h1e, 6'h22, 6'h28};
localparam logic [5:0] mrlat_rtp [8] = '{6'h08, 6'h08, 6'h08, 6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h10};

//--- src/mrlat_defines.vh
// Constants for the burst and preamble mode register with latency lookup.
// Assumes inclusion by bare name from the design file under src/.
`ifndef MRLAT_DEFINES_VH
`define MRLAT_DEFINES_VH

// ----------------------------------------------------------------------
// Register address and reset value
// ----------------------------------------------------------------------
`define MRLAT_MR_ADDR 6'h01
`define MRLAT_MR_RESET 8'h04

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MRLAT_BURST_LSB 0
`define MRLAT_BURST_MSB 1
`define MRLAT_WRPRE_BIT 2
`define MRLAT_RDPRE_BIT 3
`define MRLAT_WREC_LSB 4
`define MRLAT_WREC_MSB 6
`define MRLAT_POST_BIT 7

// ----------------------------------------------------------------------
// Burst length codes
// ----------------------------------------------------------------------
`define MRLAT_BURST_FIXED16 2'h0
`define MRLAT_BURST_FIXED32 2'h1
`define MRLAT_BURST_OTF 2'h2
`define MRLAT_BURST_RSVD 2'h3

// ----------------------------------------------------------------------
// Command codes on the sampled command bus
// ----------------------------------------------------------------------
`define MRLAT_CMD_NOP 3'h0
`define MRLAT_CMD_WRITE 3'h1
`define MRLAT_CMD_READ 3'h2
`define MRLAT_CMD_MRW 3'h3
`define MRLAT_CMD_MRR 3'h4

// ----------------------------------------------------------------------
// Timing counts in link clock cycles or half cycles, and register read data
// ----------------------------------------------------------------------
`define MRLAT_BURST32_EXTRA 6'h08
`define MRLAT_WR_PRE_CYCLES 2'h2
`define MRLAT_POST_SHORT_HALF 2'h1
`define MRLAT_POST_LONG_HALF 2'h3
`define MRLAT_MRR_DATA 8'h00

`endif

//--- src/mrlat_mode_reg.v
// Burst and preamble mode register with two set points, latency lookup
// per clock band and auto-precharge start timers.
// Assumes the command bus is stable around each rising edge of ck_in and
// that the set point, inversion and band selects are local, same clock.
//
// Overview of operation
// - The burst length field picks fixed 16, fixed 32 or per-command 16/32, code 11 reserved.
// - The read preamble bit picks a static strobe preamble at 0 and a toggling one at 1.
// - The write-recovery code maps to 6,10,16,20,24,30,34,40 cycles before write precharge.
// - The postamble bit picks 0.5 clock periods at 0 and 1.5 periods at 1.
// - The register exists twice and register writes reach the copy picked by write select.
// - Only the copy picked by operate select steers behaviour.
// - Read latency uses the no-inversion column at 0 and the inversion column at 1.
// - Write latency uses set A at 0 and set B at 1.
// - Read-to-precharge per band is 8,8,8,8,10,12,14,16 cycles before read precharge.
// - A 32-beat read adds 8 cycles to the read-to-precharge count.
// - Read and write latencies per band follow the four fixed tables.
// - A register read returns undefined data while strobes still toggle.
`include "mrlat_defines.vh"

module mrlat_mode_reg #(
  parameter SYNC_STAGES = 2
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Link pins from the controller
  input wire ck_in,
  input wire [2:0] cmd_in,
  input wire [5:0] mr_addr_in,
  input wire [7:0] op_in,
  input wire burst_otf_in,
  input wire auto_precharge_in,
  // Selects from neighbouring mode registers
  input wire set_point_write_select,
  input wire set_point_operate_select,
  input wire data_bus_inversion,
  input wire write_latency_set_select,
  input wire [2:0] clock_band,
  // Active field values
  output reg [1:0] burst_length_mode,
  output reg wr_preamble_valid,
  output reg [1:0] wr_preamble_cycles,
  output reg read_preamble_toggle,
  output reg [5:0] write_recovery_cycles,
  output reg [1:0] read_postamble_half,
  // Latency lookup
  output reg [5:0] read_latency,
  output reg [5:0] write_latency,
  output reg [5:0] read_to_precharge_cycles,
  // Command effects
  output reg burst_is_32,
  output reg wr_precharge_start,
  output reg rd_precharge_start,
  output reg mrr_strobe,
  output reg [7:0] mrr_data,
  output reg mrw_reserved
);

  // ----------------------------------------------------------------------
  // Lookup functions
  // ----------------------------------------------------------------------

  // Write-recovery code to cycle count
  function [5:0] wrec_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h0: wrec_cycles = 6'h06;
        3'h1: wrec_cycles = 6'h0a;
        3'h2: wrec_cycles = 6'h10;
        3'h3: wrec_cycles = 6'h14;
        3'h4: wrec_cycles = 6'h18;
        3'h5: wrec_cycles = 6'h1e;
        3'h6: wrec_cycles = 6'h22;
        default: wrec_cycles = 6'h28;
      endcase
    end
  endfunction

  // Read latency per band, with or without inversion
  function [5:0] rdlat_lookup;
    input [2:0] band;
    input inv;
    begin
      case (band)
        3'h0: rdlat_lookup = 6'h06;
        3'h1: rdlat_lookup = inv ? 6'h0c : 6'h0a;
        3'h2: rdlat_lookup = inv ? 6'h10 : 6'h0e;
        3'h3: rdlat_lookup = inv ? 6'h16 : 6'h14;
        3'h4: rdlat_lookup = inv ? 6'h1c : 6'h18;
        3'h5: rdlat_lookup = inv ? 6'h20 : 6'h1c;
        3'h6: rdlat_lookup = inv ? 6'h24 : 6'h20;
        default: rdlat_lookup = inv ? 6'h28 : 6'h24;
      endcase
    end
  endfunction

  // Write latency per band, set A or set B
  function [5:0] wrlat_lookup;
    input [2:0] band;
    input set_b;
    begin
      case (band)
        3'h0: wrlat_lookup = 6'h04;
        3'h1: wrlat_lookup = set_b ? 6'h08 : 6'h06;
        3'h2: wrlat_lookup = set_b ? 6'h0c : 6'h08;
        3'h3: wrlat_lookup = set_b ? 6'h12 : 6'h0a;
        3'h4: wrlat_lookup = set_b ? 6'h16 : 6'h0c;
        3'h5: wrlat_lookup = set_b ? 6'h1a : 6'h0e;
        3'h6: wrlat_lookup = set_b ? 6'h1e : 6'h10;
        default: wrlat_lookup = set_b ? 6'h22 : 6'h12;
      endcase
    end
  endfunction

  // Read-to-precharge per band for 16-beat bursts
  function [5:0] rtp_lookup;
    input [2:0] band;
    begin
      case (band)
        3'h4: rtp_lookup = 6'h0a;
        3'h5: rtp_lookup = 6'h0c;
        3'h6: rtp_lookup = 6'h0e;
        3'h7: rtp_lookup = 6'h10;
        default: rtp_lookup = 6'h08;
      endcase
    end
  endfunction

  // Burst length of one command from mode and command operand
  function is_burst32;
    input [1:0] mode;
    input otf;
    begin
      case (mode)
        `MRLAT_BURST_FIXED32: is_burst32 = 1'b1;
        `MRLAT_BURST_OTF: is_burst32 = otf;
        default: is_burst32 = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  localparam PIN_W = 20;
  wire [PIN_W-1:0] pin_raw;
  reg [PIN_W-1:0] pin_meta_reg;
  reg [PIN_W-1:0] pin_sync_reg;
  reg ck_last_reg;
  wire ck_rise;

  assign pin_raw = {ck_in, cmd_in, mr_addr_in, op_in, burst_otf_in, auto_precharge_in};

  // Two flip-flops on every pin before use
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta_reg <= {PIN_W{1'b0}};
      pin_sync_reg <= {PIN_W{1'b0}};
      ck_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      ck_last_reg <= pin_sync_reg[19];
    end
  end

  // Rising link clock edge and the command it carries
  assign ck_rise = pin_sync_reg[19] & ~ck_last_reg;
  wire [2:0] s_cmd = pin_sync_reg[18:16];
  wire [5:0] s_addr = pin_sync_reg[15:10];
  wire [7:0] s_op = pin_sync_reg[9:2];
  wire s_otf = pin_sync_reg[1];
  wire s_autopre = pin_sync_reg[0];

  wire take_mrw = ck_rise & (s_cmd == `MRLAT_CMD_MRW) & (s_addr == `MRLAT_MR_ADDR);
  wire take_mrr = ck_rise & (s_cmd == `MRLAT_CMD_MRR) & (s_addr == `MRLAT_MR_ADDR);
  wire take_wr = ck_rise & (s_cmd == `MRLAT_CMD_WRITE);
  wire take_rd = ck_rise & (s_cmd == `MRLAT_CMD_READ);

  // ----------------------------------------------------------------------
  // Set point storage
  // ----------------------------------------------------------------------
  reg [7:0] sp0_reg;
  reg [7:0] sp1_reg;
  wire [7:0] active_val;

  // Write only the copy chosen by write select, hold otherwise
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sp0_reg <= `MRLAT_MR_RESET;
      sp1_reg <= `MRLAT_MR_RESET;
    end else if (take_mrw) begin
      if (set_point_write_select) begin
        sp1_reg <= s_op;
      end else begin
        sp0_reg <= s_op;
      end
    end
  end

  // Operate select alone steers the block
  assign active_val = set_point_operate_select ? sp1_reg : sp0_reg;

  wire [1:0] act_burst = active_val[`MRLAT_BURST_MSB:`MRLAT_BURST_LSB];
  wire [2:0] act_wrec = active_val[`MRLAT_WREC_MSB:`MRLAT_WREC_LSB];
  wire [5:0] wrec_now = wrec_cycles(act_wrec);
  wire [5:0] rtp_now = rtp_lookup(clock_band);

  // ----------------------------------------------------------------------
  // Auto-precharge timers, counted in link clock cycles
  // ----------------------------------------------------------------------
  reg [5:0] wr_cnt_reg;
  reg [5:0] wr_cnt_next;
  reg [5:0] rd_cnt_reg;
  reg [5:0] rd_cnt_next;
  reg wr_fire;
  reg rd_fire;
  wire cmd_burst32 = is_burst32(act_burst, s_otf);

  // Load on a command with auto-precharge, count down per link edge
  always @* begin
    wr_cnt_next = wr_cnt_reg;
    rd_cnt_next = rd_cnt_reg;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    if (ck_rise && wr_cnt_reg != 6'h00) begin
      wr_cnt_next = wr_cnt_reg - 6'h01;
      wr_fire = (wr_cnt_reg == 6'h01);
    end
    if (ck_rise && rd_cnt_reg != 6'h00) begin
      rd_cnt_next = rd_cnt_reg - 6'h01;
      rd_fire = (rd_cnt_reg == 6'h01);
    end
    if (take_wr && s_autopre) begin
      wr_cnt_next = wrec_now;
    end
    if (take_rd && s_autopre) begin
      rd_cnt_next = cmd_burst32 ? rtp_now + `MRLAT_BURST32_EXTRA : rtp_now;
    end
  end

  // Timer state
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_cnt_reg <= 6'h00;
      rd_cnt_reg <= 6'h00;
    end else begin
      wr_cnt_reg <= wr_cnt_next;
      rd_cnt_reg <= rd_cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------

  // Active fields and latency lookup
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      burst_length_mode <= `MRLAT_BURST_FIXED16;
      wr_preamble_valid <= 1'b1;
      wr_preamble_cycles <= `MRLAT_WR_PRE_CYCLES;
      read_preamble_toggle <= 1'b0;
      write_recovery_cycles <= 6'h06;
      read_postamble_half <= `MRLAT_POST_SHORT_HALF;
      read_latency <= 6'h06;
      write_latency <= 6'h04;
      read_to_precharge_cycles <= 6'h08;
    end else begin
      burst_length_mode <= act_burst;
      wr_preamble_valid <= active_val[`MRLAT_WRPRE_BIT];
      wr_preamble_cycles <= `MRLAT_WR_PRE_CYCLES;
      read_preamble_toggle <= active_val[`MRLAT_RDPRE_BIT];
      write_recovery_cycles <= wrec_now;
      read_postamble_half <= active_val[`MRLAT_POST_BIT] ?
        `MRLAT_POST_LONG_HALF : `MRLAT_POST_SHORT_HALF;
      read_latency <= rdlat_lookup(clock_band, data_bus_inversion);
      write_latency <= wrlat_lookup(clock_band, write_latency_set_select);
      read_to_precharge_cycles <= rtp_now;
    end
  end

  // Command effects: burst size, precharge pulses, register read
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      burst_is_32 <= 1'b0;
      wr_precharge_start <= 1'b0;
      rd_precharge_start <= 1'b0;
      mrr_strobe <= 1'b0;
      mrr_data <= `MRLAT_MRR_DATA;
      mrw_reserved <= 1'b0;
    end else begin
      if (take_wr || take_rd) begin
        burst_is_32 <= cmd_burst32;
      end
      wr_precharge_start <= wr_fire;
      rd_precharge_start <= rd_fire;
      mrr_strobe <= take_mrr;
      mrr_data <= `MRLAT_MRR_DATA;
      mrw_reserved <= take_mrw &
        ((s_op[`MRLAT_BURST_MSB:`MRLAT_BURST_LSB] == `MRLAT_BURST_RSVD) |
         ~s_op[`MRLAT_WRPRE_BIT]);
    end
  end

endmodule // mrlat_mode_reg
